/* bench/mgmt_host.sv */
`timescale 1ns/1ps
module mgmt_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  output logic             o_wr,
  output logic             o_rd,
  output logic [4:0]       o_addr,
  output logic [15:0]      o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 5'h00;
    o_wdata = 16'h0000;
  end
  // released lines show inverted junk so stale values never pass
  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge i_clk);
    {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
    @(negedge i_clk);
    {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    q = (i_rvalid === 1'b1) ? i_rdata : 16'hxxxx;
  endtask
endmodule

/* bench/phy_ctl_monitor.sv */
`timescale 1ns/1ps
module phy_ctl_monitor (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [4:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_an_speed_100,
  input wire logic        i_an_full_duplex,
  input wire logic        o_loopback,
  input wire logic        o_speed_100,
  input wire logic        o_full_duplex,
  input wire logic        o_autoneg_en,
  input wire logic        o_autoneg_restart,
  input wire logic        o_power_down,
  input wire logic        o_isolate,
  input wire logic        o_soft_reset,
  input wire logic        o_vendor_sel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire ctl_wr     = i_wr && i_addr == 5'h00 && !o_soft_reset;
  wire rst_wr     = ctl_wr && i_wdata[15];
  wire fld_wr     = ctl_wr && !i_wdata[15];
  wire an_match   = o_speed_100 == i_an_speed_100 && o_full_duplex == i_an_full_duplex;
  wire mode_clear = !o_loopback && !o_isolate && !o_power_down;
  rd_answer_a: assert property (i_rd && !o_soft_reset |=> o_rvalid)
    else $error("read not answered");
  vendor_decode_a: assert property (o_vendor_sel == (i_addr >= 5'h10))
    else $error("vendor select wrong");
  reserved_zero_a: assert property (o_rvalid |-> (o_rdata & 16'h827f) == '0)
    else $error("reserved read bits set");
  loopback_wr_a: assert property (fld_wr |=> o_loopback == $past(i_wdata[14]))
    else $error("loopback not written");
  an_override_a: assert property (o_autoneg_en |-> an_match)
    else $error("negotiated result not used");
  soft_start_a: assert property (rst_wr && !o_power_down |-> ##[1:2] o_soft_reset)
    else $error("soft reset not started");
  soft_len_a: assert property ($rose(o_soft_reset) |-> o_soft_reset [*4] ##1 !o_soft_reset)
    else $error("soft reset length wrong");
  pd_exit_a: assert property (rst_wr && o_power_down |=> !o_power_down && !o_soft_reset)
    else $error("power-down exit wrong");
  restart_pulse_a: assert property (fld_wr && i_wdata[9] |=> o_autoneg_restart)
    else $error("restart pulse missing");
  soft_defaults_a: assert property ($fell(o_soft_reset) |-> mode_clear)
    else $error("soft reset left mode bits");
  cover property ($rose(o_soft_reset));
  cover property (ctl_wr && i_wdata[15] && o_power_down);
  cover property (o_rvalid && o_rdata != 16'h0000);
endmodule
bind phy_basic_control_register phy_ctl_monitor mon (.*);

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        strap = 1'b1;
  logic        an_s = 1'b0;
  logic        an_d = 1'b0;
  logic        wr, rd, rvalid, lb, sp, fd, ae, pd, iso, col, sr;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, m, q;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          seed = 41;
  wire [4:0]   mode_seen = {lb, ae, pd, iso, col};
  always #10 i_clk = ~i_clk;
  phy_basic_control_register dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_speed_negotiation_strap(strap), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .o_rvalid(rvalid),
    .i_an_speed_100(an_s), .i_an_full_duplex(an_d), .o_loopback(lb), .o_speed_100(sp),
    .o_full_duplex(fd), .o_autoneg_en(ae), .o_autoneg_restart(), .o_power_down(pd),
    .o_isolate(iso), .o_col_test(col), .o_soft_reset(sr), .o_vendor_sel());
  mgmt_host host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));
  function automatic logic [15:0] next_ctl(logic [15:0] c, logic [15:0] d, logic s);
    if (!d[15]) return d & 16'h7d80;
    if (c[11]) return c & 16'h7580;
    return {2'b00, s, s, 4'h1, 8'h00};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic put(input logic [15:0] d);
    host.access(1'b1, 5'h00, d, q);
    m = next_ctl(m, d, strap);
  endtask
  task automatic get(input logic [4:0] a, input logic [15:0] e);
    host.access(1'b0, a, 16'h0000, q);
    chk("rdata", e, q);
  endtask
  // soft reset may start one edge late, so skip ahead before polling
  task automatic settle();
    repeat (3) @(negedge i_clk);
    for (int i = 0; i < 20 && sr !== 1'b0; i++) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    m = 16'h3100;
    repeat (12) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (3) @(negedge i_clk);
    get(5'h00, 16'h3100);
    $display("test reset_values done");
    for (int i = 0; i < 30; i++)
    begin
      {an_s, an_d} = 2'($random(seed));
      put(16'($random(seed)) & 16'h7fff);
      chk("mode", 16'({m[14], m[12:10], m[7]}), 16'(mode_seen));
      chk("rate", 16'(m[12] ? {an_s, an_d} : {m[13], m[8]}), 16'({sp, fd}));
      addr_w: host.access(1'b1, 5'($random(seed)) | 5'h01, 16'($random(seed)), q);
      get(5'($random(seed)) | 5'h01, 16'h0000);
      get(5'h00, m);
    end
    $display("test random_access done");
    strap = 1'b0;
    put(16'h0000);
    put(16'h8000);
    settle();
    get(5'h00, 16'h0100);
    $display("test soft_reset done");
    put(16'h4800);
    put(16'h8000);
    get(5'h00, 16'h4000);
    put(16'h8000);
    settle();
    get(5'h00, 16'h0100);
    $display("test power_down_exit done");
    put(16'h4480);
    chk("mode", 16'({m[14], m[12:10], m[7]}), 16'(mode_seen));
    strap = 1'b1;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (3) @(negedge i_clk);
    m = 16'h3100;
    get(5'h00, m);
    $display("test mid_reset done");
    end_sim();
  end
endmodule

/* rtl/phy_basic_control_register.sv */
`timescale 1ns/1ps
module phy_basic_control_register #(
  parameter int REG_NUM = phy_mgmt_pkg::REG_COUNT
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_srst,
  input  wire logic                                i_speed_negotiation_strap,
  input  wire logic                                i_wr,
  input  wire logic                                i_rd,
  input  wire logic [phy_mgmt_pkg::REG_ADDR_W-1:0] i_addr,
  input  wire logic [phy_mgmt_pkg::REG_DATA_W-1:0] i_wdata,
  output logic      [phy_mgmt_pkg::REG_DATA_W-1:0] o_rdata,
  output logic                                     o_rvalid,
  input  wire logic                                i_an_speed_100,
  input  wire logic                                i_an_full_duplex,
  output logic                                     o_loopback,
  output logic                                     o_speed_100,
  output logic                                     o_full_duplex,
  output logic                                     o_autoneg_en,
  output logic                                     o_autoneg_restart,
  output logic                                     o_power_down,
  output logic                                     o_isolate,
  output logic                                     o_col_test,
  output logic                                     o_soft_reset,
  output logic                                     o_vendor_sel
);
  localparam int DW = phy_mgmt_pkg::REG_DATA_W;

  // elaboration checks: the word layout below is fixed by hand
  if (REG_NUM != phy_mgmt_pkg::REG_COUNT)
  begin
    $error("register space must hold 32 registers");
  end
  if ((1 << phy_mgmt_pkg::REG_ADDR_W) != REG_NUM)
  begin
    $error("address width does not span the register space");
  end
  if (phy_mgmt_pkg::VENDOR_REG_FIRST != phy_mgmt_pkg::STD_REG_COUNT)
  begin
    $error("vendor registers must follow the standard ones");
  end
  if (phy_mgmt_pkg::PHY_BASIC_CONTROL >= phy_mgmt_pkg::VENDOR_REG_FIRST)
  begin
    $error("control register must sit in the standard range");
  end
  if (DW != 16 || phy_mgmt_pkg::CTL_SOFT_RESET != DW - 1 || phy_mgmt_pkg::CTL_COL_TEST != 7)
  begin
    $error("bit positions out of step with the control word");
  end
  if (phy_mgmt_pkg::SOFT_RESET_CYCLES < 1)
  begin
    $error("soft reset needs at least one cycle");
  end

  logic strap_meta_q;
  logic strap_sync_q;
  logic strap_lat_q;
  logic lat_pend_q;
  logic start_q;
  logic soft_busy;
  logic loc_rst;
  phy_mgmt_pkg::mgmt_req_s  req;
  phy_mgmt_pkg::phy_mode_s  mode_q;
  phy_mgmt_pkg::phy_mode_s  mode_d;
  logic                     an_restart_q;
  logic [DW-1:0]            ctl_word;
  logic [DW-1:0]            rdata_q;
  logic [DW-1:0]            rdata_d;
  logic                     rvalid_q;
  logic                     sel_ctl;
  logic                     wr_ctl;
  logic                     rst_req;
  logic                     rst_clears_pd;
  logic                     rst_fires;
  logic                     wr_fields;
  logic                     an_restart_d;

  assign req.wr    = i_wr;
  assign req.rd    = i_rd;
  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;

  assign sel_ctl       = (req.addr == phy_mgmt_pkg::PHY_BASIC_CONTROL);
  assign wr_ctl        = req.wr && sel_ctl;
  assign rst_req       = wr_ctl && req.wdata[phy_mgmt_pkg::CTL_SOFT_RESET];
  // leaving power-down takes a write of its own, so the reset is held back
  assign rst_clears_pd = rst_req && mode_q.power_down;
  // a reset write in the launch cycle would reload the counter and stretch the pulse
  assign rst_fires     = rst_req && !mode_q.power_down && !start_q;
  // soft reset reuses the hardware reset path for every mode bit
  assign loc_rst       = i_srst || soft_busy;
  assign wr_fields     = wr_ctl && !rst_req;
  assign an_restart_d  = wr_fields && req.wdata[phy_mgmt_pkg::CTL_AUTONEG_RST];

  phy_soft_reset_gen #(
    .CYCLES (phy_mgmt_pkg::SOFT_RESET_CYCLES)
  ) u_soft_reset (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_start (start_q),
    .o_busy  (soft_busy)
  );

  // strap comes from a pin: two stages before use
  always_ff @(posedge i_clk)
  begin
    strap_meta_q <= i_speed_negotiation_strap;
    strap_sync_q <= strap_meta_q;
  end

  // strap followed while any reset runs and frozen at release
  always_ff @(posedge i_clk)
  begin
    lat_pend_q <= loc_rst;
    if (loc_rst)
      strap_lat_q <= strap_sync_q;
  end

  always_comb
  begin
    mode_d = mode_q;
    if (lat_pend_q)
    begin
      mode_d.speed_100  = strap_lat_q;
      mode_d.autoneg_en = strap_lat_q;
    end
    // a host write in the release cycle wins over the strap default
    if (wr_fields)
    begin
      mode_d.loopback    = req.wdata[phy_mgmt_pkg::CTL_LOOPBACK];
      mode_d.speed_100   = req.wdata[phy_mgmt_pkg::CTL_SPEED_100];
      mode_d.autoneg_en  = req.wdata[phy_mgmt_pkg::CTL_AUTONEG_EN];
      mode_d.power_down  = req.wdata[phy_mgmt_pkg::CTL_POWER_DOWN];
      mode_d.isolate     = req.wdata[phy_mgmt_pkg::CTL_ISOLATE];
      mode_d.full_duplex = req.wdata[phy_mgmt_pkg::CTL_FULL_DUPLEX];
      mode_d.col_test    = req.wdata[phy_mgmt_pkg::CTL_COL_TEST];
    end
    if (rst_clears_pd)
      mode_d.power_down = 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    // speed and negotiation enable read zero until the strap is applied at release
    if (loc_rst)
    begin
      mode_q.loopback    <= phy_mgmt_pkg::CTL_LOOPBACK_RST;
      mode_q.speed_100   <= 1'b0;
      mode_q.autoneg_en  <= 1'b0;
      mode_q.power_down  <= phy_mgmt_pkg::CTL_POWER_DOWN_RST;
      mode_q.isolate     <= phy_mgmt_pkg::CTL_ISOLATE_RST;
      mode_q.full_duplex <= phy_mgmt_pkg::CTL_FULL_DUPLEX_RST;
      mode_q.col_test    <= phy_mgmt_pkg::CTL_COL_TEST_RST;
      an_restart_q       <= 1'b0;
      start_q            <= 1'b0;
    end
    else
    begin
      mode_q       <= mode_d;
      // one-cycle pulse, kept out of the read word, so the bit is never seen set on read
      an_restart_q <= an_restart_d;
      start_q      <= rst_fires;
    end
  end

  // self-clearing bits read zero, reserved low bits read zero
  assign ctl_word = {1'b0,
                     mode_q.loopback,
                     mode_q.speed_100,
                     mode_q.autoneg_en,
                     mode_q.power_down,
                     mode_q.isolate,
                     1'b0,
                     mode_q.full_duplex,
                     mode_q.col_test,
                     7'h00};

  // vendor and unimplemented addresses answer zero
  assign rdata_d = sel_ctl ? ctl_word : 16'h0000;

  // only the hardware reset clears read data, so a read during a soft reset still answers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= req.rd;
      if (req.rd)
        rdata_q <= rdata_d;
    end
  end

  assign o_rdata           = rdata_q;
  assign o_rvalid          = rvalid_q;
  assign o_loopback        = mode_q.loopback;
  // negotiated result wins while negotiation is enabled
  assign o_speed_100       = mode_q.autoneg_en ? i_an_speed_100 : mode_q.speed_100;
  assign o_full_duplex     = mode_q.autoneg_en ? i_an_full_duplex : mode_q.full_duplex;
  assign o_autoneg_en      = mode_q.autoneg_en;
  assign o_autoneg_restart = an_restart_q;
  assign o_power_down      = mode_q.power_down;
  assign o_isolate         = mode_q.isolate;
  assign o_col_test        = mode_q.col_test;
  assign o_soft_reset      = soft_busy;
  assign o_vendor_sel      = (req.addr >= phy_mgmt_pkg::VENDOR_REG_FIRST);
endmodule

/* rtl/phy_mgmt_pkg.sv */
package phy_mgmt_pkg;

  localparam int          REG_ADDR_W        = 5;
  localparam int          REG_DATA_W        = 16;
  localparam int          REG_COUNT         = 32;
  localparam int          STD_REG_COUNT     = 16;
  localparam logic [4:0]  PHY_BASIC_CONTROL = 5'h00;
  localparam logic [4:0]  VENDOR_REG_FIRST  = 5'h10;

  // bit positions of the basic control register
  localparam int CTL_SOFT_RESET  = 15;
  localparam int CTL_LOOPBACK    = 14;
  localparam int CTL_SPEED_100   = 13;
  localparam int CTL_AUTONEG_EN  = 12;
  localparam int CTL_POWER_DOWN  = 11;
  localparam int CTL_ISOLATE     = 10;
  localparam int CTL_AUTONEG_RST = 9;
  localparam int CTL_FULL_DUPLEX = 8;
  localparam int CTL_COL_TEST    = 7;

  localparam logic CTL_LOOPBACK_RST    = 1'b0;
  localparam logic CTL_POWER_DOWN_RST  = 1'b0;
  localparam logic CTL_ISOLATE_RST     = 1'b0;
  localparam logic CTL_FULL_DUPLEX_RST = 1'b1;
  localparam logic CTL_COL_TEST_RST    = 1'b0;

  // cycles the internal soft reset pulse is held
  localparam int SOFT_RESET_CYCLES = 4;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wdata;
  } mgmt_req_s;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
    logic power_down;
    logic isolate;
    logic col_test;
  } phy_mode_s;

endpackage

/* rtl/phy_soft_reset_gen.sv */
`timescale 1ns/1ps
module phy_soft_reset_gen #(
  parameter int CYCLES = phy_mgmt_pkg::SOFT_RESET_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_start,
  output logic      o_busy
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  if (CYCLES < 1)
  begin
    $error("CYCLES must be at least 1");
  end

  assign cnt_d = i_start ? CW'(CYCLES) : ((cnt_q != '0) ? cnt_q - CW'(1) : cnt_q);
  assign o_busy = (cnt_q != '0);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule
